// file: common/sdh_pkg.sv
// Constants of the receive alarm status and interrupt enable bank.
// Assumes an APB slave with 32-bit data; registers are 8 bits in the low byte.
package sdh_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PROT_IE    = 8'hB3;
	localparam logic [7:0] IDX_ADAPT_IE   = 8'hB4;
	localparam logic [7:0] IDX_PATH_IE    = 8'hB5;
	localparam logic [7:0] IDX_RETIME_IE  = 8'hB6;
	localparam logic [7:0] IDX_XMT_IE     = 8'hE1;
	localparam logic [7:0] IDX_REGEN_ST   = 8'hC0;
	localparam logic [7:0] IDX_MUX_ST     = 8'hC1;
	localparam logic [7:0] IDX_PROT_ST    = 8'hC3;
	localparam logic [7:0] IDX_ADAPT_ST   = 8'hC4;
	localparam logic [7:0] IDX_PATH_ST    = 8'hC5;
	localparam logic [7:0] IDX_DEGRADE    = 8'h21;
	localparam logic [7:0] IDX_CONFIG     = 8'hF0;
	localparam logic [7:0] IDX_EXP_LABEL  = 8'hF1;
	localparam logic [7:0] IDX_PROT_SRC   = 8'hF3;
	localparam logic [7:0] IDX_ADAPT_SRC  = 8'hF4;
	localparam logic [7:0] IDX_PATH_SRC   = 8'hF5;

	// Regenerator section status bits
	localparam int LOS_BIT = 2;
	localparam int LOF_BIT = 1;
	localparam int OOF_BIT = 0;
	// Multiplexer section status bits
	localparam int FAIL_BIT   = 5;
	localparam int RDI_BIT    = 4;
	localparam int EXCB2_BIT  = 3;
	localparam int MSAIS_BIT  = 2;
	localparam int J0MM_BIT   = 1;
	localparam int J0CRC_BIT  = 0;
	// Protection status bits
	localparam int PSF_BIT = 3;
	localparam int PSD_BIT = 2;
	// Adaptation status bits
	localparam int LOP_BIT   = 7;
	localparam int NDF_BIT   = 6;
	localparam int AUAIS_BIT = 5;
	localparam int VCAIS_BIT = 2;
	// Path status bits; bits 1:0 are overflow-only sources
	localparam int J1MM_BIT  = 7;
	localparam int J1CRC_BIT = 6;
	localparam int UNEQ_BIT  = 5;
	localparam int SLM_BIT   = 4;
	localparam int LOM_BIT   = 2;
	localparam int OVF_LSB   = 0;
	// Degrade control and configuration bits
	localparam int DEGRADE_BIT  = 1;
	localparam int SLAVE_BIT    = 0;
	localparam int BERFAIL_BIT  = 1;
	localparam int SSCHECK_BIT  = 2;
	localparam int UNEQQUAL_BIT = 3;

	// Codes and patterns
	localparam logic [2:0]  K2_RDI_CODE   = 3'h6;
	localparam logic [2:0]  K2_AIS_CODE   = 3'h7;
	localparam logic [1:0]  SS_EXPECTED   = 2'h2;
	localparam logic [15:0] PTR_ALL_ONES  = 16'hFFFF;
	localparam logic [7:0]  LABEL_ONES    = 8'hFF;
	localparam logic [7:0]  LABEL_ZERO    = 8'h00;
	localparam logic [7:0]  LABEL_ONE     = 8'h01;

	// Reset values
	localparam logic [7:0] IE_RESET     = 8'h00;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] LABEL_RESET  = 8'h00;
	localparam logic [7:0] SRC_RESET    = 8'h00;

	// Implemented bits of the status view, degrade and configuration registers
	localparam logic [7:0] REGEN_MASK  = 8'h07;
	localparam logic [7:0] MUX_MASK    = 8'h3F;
	localparam logic [7:0] PROT_MASK   = 8'h0C;
	localparam logic [7:0] ADAPT_MASK  = 8'hE4;
	localparam logic [7:0] PATH_MASK   = 8'hF7;
	localparam logic [7:0] DEGRADE_MASK = 8'h02;
	localparam logic [7:0] CONFIG_MASK  = 8'h0F;
endpackage : sdh_pkg

// file: core/sdh_rx_alarm_status_bank.sv
// Receive alarm status views, event sources and interrupt enables on APB.
// Assumes detector levels are synchronous to clock and stable per cycle.
module sdh_rx_alarm_status_bank #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Section detectors
	input  wire logic              signalLossStatus,
	input  wire logic              frameLossStatus,
	input  wire logic              outOfFrameStatus,
	input  wire logic              excessiveB2Status,
	input  wire logic              sectionTraceMismatchStatus,
	input  wire logic              sectionTraceCrcStatus,
	input  wire logic [7:0]        receivedApsByte2,
	// Pointer and path detectors
	input  wire logic              pointerInvalid,
	input  wire logic [1:0]        pointerSizeBits,
	input  wire logic              newDataFlagStatus,
	input  wire logic [15:0]       receivedPointer,
	input  wire logic [7:0]        receivedLabel,
	input  wire logic              pathTraceMismatchStatus,
	input  wire logic              pathTraceCrcStatus,
	input  wire logic              unequippedQualifier,
	input  wire logic              multiframeLossStatus,
	// Counter overflow events, set and clear pulses
	input  wire logic [1:0]        pathOverflowSet,
	input  wire logic [1:0]        pathOverflowClear,
	// Sources owned by the retiming and transmit blocks
	input  wire logic [7:0]        retimeIrqSource,
	input  wire logic [7:0]        xmtIrqSource,
	// Protection bus, two-way pins
	input  wire logic              protectionBusFailIn,
	output logic                   protectionBusFailOut,
	output logic                   protectionBusFailOe,
	input  wire logic              protectionBusDegradeIn,
	output logic                   protectionBusDegradeOut,
	output logic                   protectionBusDegradeOe,
	// Alarm and interrupt outputs
	output logic                   signalFailOut,
	output logic                   irq
);

	// Index match, used by every register decode
	function automatic logic hitIdx(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hitIdx = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
	endfunction : hitIdx

	// Software-held state
	logic [7:0] protIe_r;
	logic [7:0] adaptIe_r;
	logic [7:0] pathIe_r;
	logic [7:0] retimeIe_r;
	logic [7:0] xmtIe_r;
	logic [7:0] degradeCtrl_r;
	logic [7:0] config_r;
	logic [7:0] expLabel_r;
	// Event sources and change tracking
	logic [7:0] protSrc_r;
	logic [7:0] adaptSrc_r;
	logic [7:0] pathSrc_r;
	logic [7:0] protPrev_r;
	logic [7:0] adaptPrev_r;
	logic [7:0] pathPrev_r;
	logic       primed_r;
	// Output flops
	logic       signalFail_r;
	logic       degradeOut_r;
	logic [31:0] rdata_r;
	logic       slvErr_r;

	// Configuration fields
	wire slaveMode    = config_r[sdh_pkg::SLAVE_BIT];
	wire berFailEn    = config_r[sdh_pkg::BERFAIL_BIT];
	wire ssCheckEn    = config_r[sdh_pkg::SSCHECK_BIT];
	wire uneqQualEn   = config_r[sdh_pkg::UNEQQUAL_BIT];

	// Decoded alarms
	wire msRemoteDefect = receivedApsByte2[2:0] == sdh_pkg::K2_RDI_CODE;
	wire msAlarmInd     = receivedApsByte2[2:0] == sdh_pkg::K2_AIS_CODE;
	wire sectionFail    = msAlarmInd | (berFailEn & excessiveB2Status);
	wire pointerLoss    = pointerInvalid |
		(ssCheckEn & (pointerSizeBits != sdh_pkg::SS_EXPECTED));
	wire pointerAis     = receivedPointer == sdh_pkg::PTR_ALL_ONES;
	wire containerAis   = receivedLabel == sdh_pkg::LABEL_ONES;
	// Qualifier only consulted when the configuration asks for it
	wire pathUnequipped = (receivedLabel == sdh_pkg::LABEL_ZERO) &
		(unequippedQualifier | ~uneqQualEn);
	wire labelMismatch  = (receivedLabel != expLabel_r) &
		(receivedLabel != sdh_pkg::LABEL_ZERO) &
		(receivedLabel != sdh_pkg::LABEL_ONE);

	// Live status views, reserved bits zero
	logic [7:0] regenStat;
	logic [7:0] muxStat;
	logic [7:0] protStat;
	logic [7:0] adaptStat;
	logic [7:0] pathStat;

	// Regenerator and multiplexer section views
	always_comb begin
		regenStat = 8'h00;
		regenStat[sdh_pkg::LOS_BIT] = signalLossStatus;
		regenStat[sdh_pkg::LOF_BIT] = frameLossStatus;
		regenStat[sdh_pkg::OOF_BIT] = outOfFrameStatus;
		muxStat = 8'h00;
		muxStat[sdh_pkg::FAIL_BIT]  = sectionFail;
		muxStat[sdh_pkg::RDI_BIT]   = msRemoteDefect;
		muxStat[sdh_pkg::EXCB2_BIT] = excessiveB2Status;
		muxStat[sdh_pkg::MSAIS_BIT] = msAlarmInd;
		muxStat[sdh_pkg::J0MM_BIT]  = sectionTraceMismatchStatus;
		muxStat[sdh_pkg::J0CRC_BIT] = sectionTraceCrcStatus;
	end

	// Protection, adaptation and path views
	always_comb begin
		protStat = 8'h00;
		protStat[sdh_pkg::PSF_BIT] = protectionBusFailIn;
		protStat[sdh_pkg::PSD_BIT] = protectionBusDegradeIn;
		adaptStat = 8'h00;
		adaptStat[sdh_pkg::LOP_BIT]   = pointerLoss;
		adaptStat[sdh_pkg::NDF_BIT]   = newDataFlagStatus;
		adaptStat[sdh_pkg::AUAIS_BIT] = pointerAis;
		adaptStat[sdh_pkg::VCAIS_BIT] = containerAis;
		pathStat = 8'h00;
		pathStat[sdh_pkg::J1MM_BIT]  = pathTraceMismatchStatus;
		pathStat[sdh_pkg::J1CRC_BIT] = pathTraceCrcStatus;
		pathStat[sdh_pkg::UNEQ_BIT]  = pathUnequipped;
		pathStat[sdh_pkg::SLM_BIT]   = labelMismatch;
		pathStat[sdh_pkg::LOM_BIT]   = multiframeLossStatus;
	end

	// Bus phases; the slave never inserts wait states
	wire setupPhase  = psel & ~penable;
	wire accessPhase = psel & penable;
	wire wrLow       = accessPhase & pwrite & pstrb[0];
	wire rdAccess    = accessPhase & ~pwrite;

	// Register decode
	wire selProtIe   = hitIdx(paddr, sdh_pkg::IDX_PROT_IE);
	wire selAdaptIe  = hitIdx(paddr, sdh_pkg::IDX_ADAPT_IE);
	wire selPathIe   = hitIdx(paddr, sdh_pkg::IDX_PATH_IE);
	wire selRetimeIe = hitIdx(paddr, sdh_pkg::IDX_RETIME_IE);
	wire selXmtIe    = hitIdx(paddr, sdh_pkg::IDX_XMT_IE);
	wire selRegenSt  = hitIdx(paddr, sdh_pkg::IDX_REGEN_ST);
	wire selMuxSt    = hitIdx(paddr, sdh_pkg::IDX_MUX_ST);
	wire selProtSt   = hitIdx(paddr, sdh_pkg::IDX_PROT_ST);
	wire selAdaptSt  = hitIdx(paddr, sdh_pkg::IDX_ADAPT_ST);
	wire selPathSt   = hitIdx(paddr, sdh_pkg::IDX_PATH_ST);
	wire selDegrade  = hitIdx(paddr, sdh_pkg::IDX_DEGRADE);
	wire selConfig   = hitIdx(paddr, sdh_pkg::IDX_CONFIG);
	wire selExpLabel = hitIdx(paddr, sdh_pkg::IDX_EXP_LABEL);
	wire selProtSrc  = hitIdx(paddr, sdh_pkg::IDX_PROT_SRC);
	wire selAdaptSrc = hitIdx(paddr, sdh_pkg::IDX_ADAPT_SRC);
	wire selPathSrc  = hitIdx(paddr, sdh_pkg::IDX_PATH_SRC);
	// Status and source registers accept no writes; those answer with an error
	wire selWritable = selProtIe | selAdaptIe | selPathIe | selRetimeIe | selXmtIe |
		selDegrade | selConfig | selExpLabel;
	wire selReadOnly = selRegenSt | selMuxSt | selProtSt | selAdaptSt | selPathSt |
		selProtSrc | selAdaptSrc | selPathSrc;
	wire mapped      = selWritable | selReadOnly;
	wire badAccess   = ~mapped | (pwrite & selReadOnly);

	// Read data mux
	wire [7:0] readByte =
		selProtIe   ? protIe_r :
		selAdaptIe  ? adaptIe_r :
		selPathIe   ? pathIe_r :
		selRetimeIe ? retimeIe_r :
		selXmtIe    ? xmtIe_r :
		selRegenSt  ? regenStat :
		selMuxSt    ? muxStat :
		selProtSt   ? protStat :
		selAdaptSt  ? adaptStat :
		selPathSt   ? pathStat :
		selDegrade  ? degradeCtrl_r :
		selConfig   ? config_r :
		selExpLabel ? expLabel_r :
		selProtSrc  ? protSrc_r :
		selAdaptSrc ? adaptSrc_r :
		selPathSrc  ? pathSrc_r : 8'h00;

	// Apart from the path overflow bits, source clear comes only from a completed read of the matching status
	wire clrProt  = rdAccess & selProtSt;
	wire clrAdapt = rdAccess & selAdaptSt;
	wire clrPath  = rdAccess & selPathSt;

	// Change events; suppressed until the first sample has been taken
	wire [7:0] protChg  = primed_r ? (protStat ^ protPrev_r) : 8'h00;
	wire [7:0] adaptChg = primed_r ? (adaptStat ^ adaptPrev_r) : 8'h00;
	wire [7:0] pathChgLive = primed_r ? (pathStat ^ pathPrev_r) : 8'h00;
	// Overflow bits have no live view, only their own set and clear
	wire [7:0] pathOvfSet = {6'h00, pathOverflowSet} << sdh_pkg::OVF_LSB;
	wire [7:0] pathOvfClr = {6'h00, pathOverflowClear} << sdh_pkg::OVF_LSB;

	// Set wins over clear, so an event in the clearing cycle survives
	wire [7:0] protSrc_nxt  = (protSrc_r & ~{8{clrProt}}) | protChg;
	wire [7:0] adaptSrc_nxt = (adaptSrc_r & ~{8{clrAdapt}}) | adaptChg;
	// Overflow bits clear only through their own pulse, never by a status read
	wire [7:0] pathOvfBits  = {6'h00, 2'h3} << sdh_pkg::OVF_LSB;
	wire [7:0] pathSrc_nxt  = (pathSrc_r &
		~(({8{clrPath}} & sdh_pkg::PATH_MASK & ~pathOvfBits) | pathOvfClr)) |
		(pathChgLive | pathOvfSet);

	// Enable gating onto the single interrupt pin
	wire irqAny = |(protSrc_r & protIe_r) | |(adaptSrc_r & adaptIe_r) |
		|(pathSrc_r & pathIe_r) | |(retimeIrqSource & retimeIe_r) |
		|(xmtIrqSource & xmtIe_r);

	// Interrupt enable registers
	always_ff @(posedge clock) begin
		if (reset) begin
			protIe_r   <= sdh_pkg::IE_RESET;
			adaptIe_r  <= sdh_pkg::IE_RESET;
			pathIe_r   <= sdh_pkg::IE_RESET;
			retimeIe_r <= sdh_pkg::IE_RESET;
			xmtIe_r    <= sdh_pkg::IE_RESET;
		end else if (wrLow) begin
			if (selProtIe) protIe_r <= pwdata[7:0];
			if (selAdaptIe) adaptIe_r <= pwdata[7:0];
			if (selPathIe) pathIe_r <= pwdata[7:0];
			if (selRetimeIe) retimeIe_r <= pwdata[7:0];
			if (selXmtIe) xmtIe_r <= pwdata[7:0];
		end
	end

	// Control registers
	always_ff @(posedge clock) begin
		if (reset) begin
			degradeCtrl_r <= sdh_pkg::CTRL_RESET;
			config_r      <= sdh_pkg::CTRL_RESET;
			expLabel_r    <= sdh_pkg::LABEL_RESET;
		end else if (wrLow) begin
			if (selDegrade) degradeCtrl_r <= pwdata[7:0] & sdh_pkg::DEGRADE_MASK;
			if (selConfig) config_r <= pwdata[7:0] & sdh_pkg::CONFIG_MASK;
			if (selExpLabel) expLabel_r <= pwdata[7:0];
		end
	end

	// Event source registers and change history
	always_ff @(posedge clock) begin
		if (reset) begin
			protSrc_r   <= sdh_pkg::SRC_RESET;
			adaptSrc_r  <= sdh_pkg::SRC_RESET;
			pathSrc_r   <= sdh_pkg::SRC_RESET;
			protPrev_r  <= sdh_pkg::SRC_RESET;
			adaptPrev_r <= sdh_pkg::SRC_RESET;
			pathPrev_r  <= sdh_pkg::SRC_RESET;
			primed_r    <= 1'b0;
		end else begin
			protSrc_r   <= protSrc_nxt;
			adaptSrc_r  <= adaptSrc_nxt;
			pathSrc_r   <= pathSrc_nxt;
			protPrev_r  <= protStat;
			adaptPrev_r <= adaptStat;
			pathPrev_r  <= pathStat;
			primed_r    <= 1'b1;
		end
	end

	// Degrade output moves only on a software write of its control bit
	always_ff @(posedge clock) begin
		if (reset) begin
			degradeOut_r <= 1'b0;
		end else if (wrLow && selDegrade) begin
			degradeOut_r <= pwdata[sdh_pkg::DEGRADE_BIT];
		end
	end

	// Fail status follows the live section fail every cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			signalFail_r <= 1'b0;
		end else begin
			signalFail_r <= sectionFail;
		end
	end

	// Read data captured in setup, presented in the access cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_r  <= 32'h0000_0000;
			slvErr_r <= 1'b0;
		end else if (setupPhase) begin
			rdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
			slvErr_r <= badAccess;
		end
	end

	// Interrupt output flop
	logic irq_r;
	always_ff @(posedge clock) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irqAny;
		end
	end

	// Outputs; partner bus is driven only in slave mode
	assign pready  = 1'b1;
	assign prdata  = rdata_r;
	assign pslverr = slvErr_r & accessPhase;
	assign signalFailOut           = signalFail_r;
	assign protectionBusFailOut    = signalFail_r;
	assign protectionBusFailOe     = slaveMode;
	assign protectionBusDegradeOut = degradeOut_r;
	assign protectionBusDegradeOe  = slaveMode;
	assign irq = irq_r;

endmodule : sdh_rx_alarm_status_bank

// file: bench/sdh_rx_alarm_status_bank_props.sv
// Concurrent checks of the alarm status bank at its top ports.
// Assumes an APB master and detector levels held steady over each transfer.
module sdh_rx_alarm_status_bank_props #(
	parameter int ADDR_W = 12
) (
	// Clock, reset and APB
	input wire logic              clock,
	input wire logic              reset,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	// Detector levels
	input wire logic              signalLossStatus,
	input wire logic              frameLossStatus,
	input wire logic              outOfFrameStatus,
	input wire logic              excessiveB2Status,
	input wire logic [7:0]        receivedApsByte2,
	input wire logic              newDataFlagStatus,
	input wire logic [15:0]       receivedPointer,
	input wire logic [7:0]        receivedLabel,
	input wire logic              multiframeLossStatus,
	// Protection bus and alarm outputs
	input wire logic              protectionBusFailIn,
	input wire logic              protectionBusDegradeIn,
	input wire logic              protectionBusFailOut,
	input wire logic              protectionBusFailOe,
	input wire logic              protectionBusDegradeOut,
	input wire logic              protectionBusDegradeOe,
	input wire logic              signalFailOut,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// Byte addresses of the watched registers
	localparam logic [ADDR_W-1:0] A_RG = ADDR_W'({sdh_pkg::IDX_REGEN_ST, 2'b00});
	localparam logic [ADDR_W-1:0] A_MX = ADDR_W'({sdh_pkg::IDX_MUX_ST, 2'b00});
	localparam logic [ADDR_W-1:0] A_PR = ADDR_W'({sdh_pkg::IDX_PROT_ST, 2'b00});
	localparam logic [ADDR_W-1:0] A_AD = ADDR_W'({sdh_pkg::IDX_ADAPT_ST, 2'b00});
	localparam logic [ADDR_W-1:0] A_PH = ADDR_W'({sdh_pkg::IDX_PATH_ST, 2'b00});
	localparam logic [ADDR_W-1:0] A_DG = ADDR_W'({sdh_pkg::IDX_DEGRADE, 2'b00});
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// Read setup then its access; data is judged against the setup-cycle levels
	sequence s_read(logic [ADDR_W-1:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	a_rd_regen:
	assert property (s_read(A_RG) |-> prdata == {29'h0, $past(signalLossStatus),
		$past(frameLossStatus), $past(outOfFrameStatus)}) else $error("regen view wrong");
	a_rd_mux:
	assert property (s_read(A_MX) |-> prdata[31:6] == 26'h0
		&& prdata[4] == (($past(receivedApsByte2) & 8'h07) == 8'h06)
		&& prdata[3] == $past(excessiveB2Status)
		&& prdata[2] == (($past(receivedApsByte2) & 8'h07) == 8'h07)) else $error("mux view wrong");
	a_rd_prot:
	assert property (s_read(A_PR) |-> prdata == {28'h0, $past(protectionBusFailIn),
		$past(protectionBusDegradeIn), 2'h0}) else $error("protection view wrong");
	a_rd_adapt:
	assert property (s_read(A_AD) |-> prdata[6] == $past(newDataFlagStatus)
		&& prdata[5] == ($past(receivedPointer) == 16'hFFFF) && prdata[4:3] == 2'h0
		&& prdata[2] == ($past(receivedLabel) == 8'hFF)) else $error("adaptation view wrong");
	a_rd_path:
	assert property (s_read(A_PH) |-> prdata[3] == 1'b0 && prdata[2] == $past(multiframeLossStatus)
		&& ($past(receivedLabel) > 8'h01 || !prdata[4])) else $error("path view wrong");
	a_sf_on_ais:
	assert property ((receivedApsByte2 & 8'h07) == 8'h07 |=> signalFailOut)
		else $error("signal fail missed alarm");
	a_bus_fail_mirror:
	assert property (protectionBusFailOut == signalFailOut && (!signalFailOut
		|| $past((receivedApsByte2 & 8'h07) == 8'h07 || excessiveB2Status)))
		else $error("bus fail differs");
	a_bus_oe_pair:
	assert property (protectionBusFailOe == protectionBusDegradeOe) else $error("enables differ");
	a_degrade_hold:
	assert property (!(psel && penable && pwrite && paddr == A_DG) |=> $stable(protectionBusDegradeOut))
		else $error("degrade moved without write");
	a_irq_after_reset:
	assert property ($fell(reset) |-> !irq) else $error("interrupt after reset");
endmodule : sdh_rx_alarm_status_bank_props

bind sdh_rx_alarm_status_bank sdh_rx_alarm_status_bank_props #(.ADDR_W(ADDR_W))
	sdh_rx_alarm_status_bank_props_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr,
	.prdata, .signalLossStatus, .frameLossStatus, .outOfFrameStatus, .excessiveB2Status,
	.receivedApsByte2, .newDataFlagStatus, .receivedPointer, .receivedLabel,
	.multiframeLossStatus, .protectionBusFailIn, .protectionBusDegradeIn, .protectionBusFailOut,
	.protectionBusFailOe, .protectionBusDegradeOut, .protectionBusDegradeOe, .signalFailOut, .irq);

// file: bench/sdh_partner_model.sv
// Protection partner device on the shared fail and degrade wires.
// Assumes the bank raises its enables only while it is the slave.
module sdh_partner_model (
	// Bank side of the two-way pins
	input  wire logic failOe,
	input  wire logic failOut,
	input  wire logic degradeOe,
	input  wire logic degradeOut,
	// Partner's own levels and the resolved wires
	input  wire logic ownFail,
	input  wire logic ownDegrade,
	output logic      failWire,
	output logic      degradeWire
);
	timeunit 1ns;
	timeprecision 1ps;
	// Whoever enables drives; the partner fills in only when the bank is silent
	assign failWire    = failOe ? failOut : ownFail;
	assign degradeWire = degradeOe ? degradeOut : ownDegrade;
endmodule : sdh_partner_model

// file: bench/sdh_rx_alarm_status_bank_bench.sv
// Self-checking bench of the alarm status bank with a protection partner.
// Assumes the bank answers APB without wait states, as its hand-over says.
module sdh_rx_alarm_status_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, reset, psel, penable, pwrite, rdy, err, bfo, bfoe, bdo, bdoe, sfo, irq;
	logic        pFail, pDeg, ais, sf, pf, pd, fw, dw;
	logic [11:0] paddr, det;
	logic [31:0] pwdata, rd, seed;
	logic [7:0]  k2, lbl, rt, xm, cfg, expL, deg;
	logic [15:0] ptr;
	logic [1:0]  ss, ovS, ovC;
	logic [32:0] expq[$];
	logic [7:0]  ies[5] = '{8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hE1};
	logic [7:0]  cfgs[3] = '{8'h02, 8'h0D, 8'h06};
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc = 0;

	// Block under test; byte strobes tied on, every lane written
	sdh_rx_alarm_status_bank sdh_rx_alarm_status_bank_inst (.clock(clock), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .pready(rdy), .prdata(rd), .pslverr(err), .signalLossStatus(det[0]),
		.frameLossStatus(det[1]), .outOfFrameStatus(det[2]), .excessiveB2Status(det[3]),
		.sectionTraceMismatchStatus(det[4]), .sectionTraceCrcStatus(det[5]),
		.receivedApsByte2(k2), .pointerInvalid(det[6]), .pointerSizeBits(ss),
		.newDataFlagStatus(det[7]), .receivedPointer(ptr), .receivedLabel(lbl),
		.pathTraceMismatchStatus(det[8]), .pathTraceCrcStatus(det[9]),
		.unequippedQualifier(det[10]), .multiframeLossStatus(det[11]), .pathOverflowSet(ovS),
		.pathOverflowClear(ovC), .retimeIrqSource(rt), .xmtIrqSource(xm),
		.protectionBusFailIn(fw), .protectionBusFailOut(bfo), .protectionBusFailOe(bfoe),
		.protectionBusDegradeIn(dw), .protectionBusDegradeOut(bdo),
		.protectionBusDegradeOe(bdoe), .signalFailOut(sfo), .irq(irq));
	// Partner resolves both shared wires
	sdh_partner_model sdh_partner_model_inst (.failOe(bfoe), .failOut(bfo), .degradeOe(bdoe),
		.degradeOut(bdo), .ownFail(pFail), .ownDegrade(pDeg), .failWire(fw), .degradeWire(dw));

	// Clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic conclude();
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// One APB transfer; the note holds the error flag and, for reads, the byte
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] v,
		input logic e);
		expq.push_back({e, wr ? 32'h0 : {24'h0, v}});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {seed[31:8], v};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : xfer

	// All five live views, expected from the present detector levels
	task automatic views();
		ais = k2[2:0] == 3'h7;
		sf = ais | (cfg[1] & det[3]);
		pf = cfg[0] ? sf : pFail;
		pd = cfg[0] ? deg[1] : pDeg;
		xfer(1'b0, 8'hC0, {5'h0, det[0], det[1], det[2]}, 1'b0);
		xfer(1'b0, 8'hC1, {2'h0, sf, k2[2:0] == 3'h6, det[3], ais, det[4], det[5]}, 1'b0);
		xfer(1'b0, 8'hC3, {4'h0, pf, pd, 2'h0}, 1'b0);
		xfer(1'b0, 8'hC4, {det[6] | (ss != 2'h2 && cfg[2]), det[7], ptr == 16'hFFFF, 2'h0,
			lbl == 8'hFF, 2'h0}, 1'b0);
		xfer(1'b0, 8'hC5, {det[8], det[9], lbl == 8'h0 && (det[10] || !cfg[3]),
			lbl != expL && lbl > 8'h01, 1'b0, det[11], 2'h0}, 1'b0);
		check({31'h0, sfo, bfo}, {31'h0, sf, sf});
	endtask : views

	// Scoreboard: oldest note against each completed transfer
	always @(posedge clock) begin
		if (psel && penable && rdy === 1'b1) begin
			check({err, pwrite ? 32'h0 : rd}, expq.pop_front());
		end
	end

	// Hang guard, far above the roughly 820 cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, det, k2, ss, ptr, lbl} = '0;
		{ovS, ovC, rt, xm, pFail, pDeg, deg, cfg, expL} = '0;
		seed = 32'h9D66;
		reset = 1'b1;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		// Enables: cleared by reset, then read back as written
		foreach (ies[i]) begin
			seed = lfsr(seed);
			xfer(1'b0, ies[i], 8'h00, 1'b0);
			xfer(1'b1, ies[i], seed[7:0], 1'b0);
			xfer(1'b0, ies[i], seed[7:0], 1'b0);
			xfer(1'b1, ies[i], 8'h00, 1'b0);
		end
		// Random detector levels under each configuration
		foreach (cfgs[c]) begin
			cfg = cfgs[c];
			expL = seed[15:8];
			xfer(1'b1, 8'hF0, cfg, 1'b0);
			xfer(1'b1, 8'hF1, expL, 1'b0);
			repeat (12) begin
				repeat (32) seed = lfsr(seed);
				{pFail, pDeg, ss, k2, det} <= seed[23:0];
				ptr <= seed[24] ? 16'hFFFF : seed[31:16];
				lbl <= seed[25] ? expL : (seed[26] ? {8{seed[27]}} : {7'h0, seed[27]});
				@(posedge clock);
				views();
			end
		end
		// Status writes ignored; unmapped place refused
		xfer(1'b1, 8'hC0, 8'hFF, 1'b1);
		xfer(1'b0, 8'hC0, {5'h0, det[0], det[1], det[2]}, 1'b0);
		xfer(1'b0, 8'h77, 8'h00, 1'b1);
		// Event source: set on change, gated by enable, cleared by reading the view
		xfer(1'b1, 8'hB5, 8'h04, 1'b0);
		views();
		check({32'h0, irq}, 33'h0);
		det[11] <= ~det[11];
		repeat (3) @(posedge clock);
		check({32'h0, irq}, 33'h1);
		views();
		// Interrupt flop lags the source clear by one edge
		@(posedge clock);
		check({32'h0, irq}, 33'h0);
		xfer(1'b1, 8'hB5, 8'h00, 1'b0);
		det[11] <= ~det[11];
		repeat (3) @(posedge clock);
		check({32'h0, irq}, 33'h0);
		xfer(1'b0, 8'hF5, 8'h04, 1'b0);
		views();
		xfer(1'b0, 8'hF5, 8'h00, 1'b0);
		// Counter overflow source has no view bit
		xfer(1'b1, 8'hB5, 8'h01, 1'b0);
		ovS <= 2'b01;
		@(posedge clock);
		ovS <= 2'b00;
		// Status read in between must leave the overflow source set
		views();
		xfer(1'b0, 8'hF5, 8'h01, 1'b0);
		check({32'h0, irq}, 33'h1);
		ovC <= 2'b01;
		@(posedge clock);
		ovC <= 2'b00;
		xfer(1'b0, 8'hF5, 8'h00, 1'b0);
		// Outside sources reach the pin only through their own enable bit
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, i ? 8'hE1 : 8'hB6, 8'h40, 1'b0);
			{xm, rt} <= i ? 16'hC000 : 16'h00C0;
			repeat (3) @(posedge clock);
			check({32'h0, irq}, 33'h1);
			xfer(1'b1, i ? 8'hE1 : 8'hB6, 8'h01, 1'b0);
			@(posedge clock);
			check({32'h0, irq}, 33'h0);
			{xm, rt} <= 16'h0;
		end
		// Slave: bus enabled, degrade follows writes only
		cfg = 8'h01;
		xfer(1'b1, 8'hF0, cfg, 1'b0);
		check({31'h0, bfoe, bdoe}, 33'h3);
		deg = 8'h02;
		xfer(1'b1, 8'h21, 8'hFF, 1'b0);
		check({32'h0, bdo}, 33'h1);
		xfer(1'b0, 8'h21, deg, 1'b0);
		views();
		deg = 8'h00;
		xfer(1'b1, 8'h21, 8'hFD, 1'b0);
		check({32'h0, bdo}, 33'h0);
		views();
		repeat (2) @(posedge clock);
		conclude();
	end
endmodule : sdh_rx_alarm_status_bank_bench
